/* rtl/ccri_map.svh */
`ifndef CCRI_MAP_SVH
`define CCRI_MAP_SVH
// =====================================
// Command codes
`define CCRI_CMD_DATE 16'h0086
`define CCRI_CMD_SER_LO 16'h0087
`define CCRI_CMD_SER_HI 16'h0088
`define CCRI_CMD_SCALE 16'h00C0
`define CCRI_CMD_STATUS 16'h00C1
`define CCRI_CMD_SETUP 16'h00C2
// =====================================
// Frame identifiers, low byte is the unit address
`define CCRI_ID_WRITE 20'hC0100
`define CCRI_ID_READ 20'hC0100
`define CCRI_ID_RESP 20'hC0000
`define CCRI_ID_BASE_MASK 20'hFFF00
`define CCRI_DLC_WRITE 4'h4
`define CCRI_DLC_READ 4'h2
// =====================================
// Field positions
`define CCRI_ST_MASTER 0
`define CCRI_ST_SECONDARY_OUTPUT_GOOD 1
`define CCRI_ST_POWER_FACTOR_STAGE_GOOD 2
`define CCRI_ST_DUMMY 4
`define CCRI_ST_INIT 5
`define CCRI_ST_MEMERR 6
`define CCRI_CFG_BUS_CTRL 0
`define CCRI_CFG_INIT_LO 1
`define CCRI_CFG_INIT_HI 2
`define CCRI_CFG_MASK 16'h0007
`define CCRI_SETUP_RESET 16'h0000
`define CCRI_FACTOR_NONE 4'h0
`define CCRI_FACTOR_MIN 4'h4
`define CCRI_FACTOR_MAX 4'h9
`endif

/* rtl/ccri_pkg.sv */
package ccri_pkg;
  typedef struct packed {
    logic [19:0] id;
    logic [3:0] dlc;
    logic [7:0][7:0] data;
  } ccri_frame_t;
  typedef struct packed {
    logic param_memory_error;
    logic in_init;
    logic dummy_load_active;
    logic power_factor_stage_good;
    logic secondary_output_good;
    logic is_master;
  } ccri_status_t;
  typedef struct packed {
    logic [3:0] input_current_multiplier;
    logic [3:0] temperature_multiplier;
    logic [3:0] fan_speed_multiplier;
    logic [3:0] input_voltage_multiplier;
    logic [3:0] output_current_multiplier;
    logic [3:0] output_voltage_multiplier;
  } ccri_scale_t;
  typedef enum logic [1:0] {
    CCRI_PWR_OFF,
    CCRI_PWR_ON,
    CCRI_PWR_PREVIOUS,
    CCRI_PWR_RESERVED
  } ccri_pwr_init_t;
endpackage

/* rtl/ccri_top.sv */
`timescale 1ns/1ns
`include "ccri_map.svh"
// Contract
// - Date register returns six ASCII digits year, month, day, byte 0 first.
// - Serial text spans two six-byte registers: date then running count.
// - Scale byte 0 bits 0..3 hold the output-voltage factor code.
// - Factor codes: 0 unsupported, 4..9 select 0.001 up to 100.
// - Scale byte 0 bits 4..7 hold the output-current factor code.
// - Scale byte 1 holds input-voltage low nibble, fan-speed high nibble.
// - Scale byte 2 holds temperature code low nibble, upper bits reserved.
// - Scale byte 3 holds input-current code low; bytes 4 and 5 reserved.
// - Status bit 0 reads 1 when this unit is parallel master.
// - Status bit 1 reads 1 when secondary output voltage is normal.
// - Status bit 2 reads 1 when power-factor stage is on and normal.
// - Status bit 4 reads 1 while the dummy load is on.
// - Status bit 5 reads 1 during initialization.
// - Status bit 6 reads 1 after a parameter memory access failure.
// - Unsupported and unassigned status or setup bits read zero.
// - Setup bit 0 selects analog inputs or bus commands for output control.
// - Setup bits 1..2 choose power-up on/off state; 3 reserved.
// - Command code and parameters travel low byte first.
// - Device answers on response identifier with its address, echoing command.
// - Both nodes use extended identifiers at 250 kbit/s.
// - Fault low byte flags fan, temperature, voltage, current, short, input, off, hot.
module ccri_top #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic [ADDR_W-1:0] unit_addr_in,
  input wire logic rx_valid_in,
  input wire ccri_pkg::ccri_frame_t rx_frame_in,
  input wire logic tx_ready_in,
  output logic tx_valid_out,
  output ccri_pkg::ccri_frame_t tx_frame_out,
  input wire logic [47:0] date_text_in,
  input wire logic [47:0] count_text_in,
  input wire ccri_pkg::ccri_scale_t scale_in,
  input wire ccri_pkg::ccri_status_t status_in,
  input wire logic [7:0] fault_in,
  input wire logic [15:0] output_voltage_setpoint_in,
  input wire logic [15:0] output_current_setpoint_in,
  output logic bus_control_out,
  output logic [1:0] power_up_mode_out,
  output logic setup_write_out,
  output logic [15:0] output_voltage_setpoint_out,
  output logic [15:0] output_current_setpoint_out,
  output logic [7:0] fault_flags_out
);
  import ccri_pkg::*;

  initial begin
    if (ADDR_W != 8) begin
      $error("ccri_top serves only an 8-bit unit address");
    end
  end

  // =====================================
  // Frame decode
  logic [15:0] cmd_w;
  logic [15:0] param_w;
  logic addr_hit_w;
  logic is_write_w;
  logic is_read_w;
  logic [7:0] rd_len_w;
  logic [47:0] rd_data_w;
  logic known_w;

  function automatic logic [3:0] ccri_code_ok(input logic [3:0] code);
    // Codes outside the defined set are reported as unsupported
    ccri_code_ok = (code == `CCRI_FACTOR_NONE ||
                    (code >= `CCRI_FACTOR_MIN && code <= `CCRI_FACTOR_MAX)) ? code : `CCRI_FACTOR_NONE;
  endfunction

  assign cmd_w = {rx_frame_in.data[1], rx_frame_in.data[0]};
  assign param_w = {rx_frame_in.data[3], rx_frame_in.data[2]};
  // Only 20 identifier bits of the extended form are carried; the link below handles the bit rate
  assign addr_hit_w = (rx_frame_in.id[7:0] == unit_addr_in);
  assign is_write_w = rx_valid_in && addr_hit_w && rx_frame_in.dlc == `CCRI_DLC_WRITE &&
                      (rx_frame_in.id & `CCRI_ID_BASE_MASK) == `CCRI_ID_WRITE;
  assign is_read_w = rx_valid_in && addr_hit_w && rx_frame_in.dlc == `CCRI_DLC_READ &&
                     (rx_frame_in.id & `CCRI_ID_BASE_MASK) == `CCRI_ID_READ;

  // =====================================
  // Register storage
  logic [15:0] setup_r;
  logic [15:0] setup_nxt;
  logic [15:0] vset_r;
  logic [15:0] iset_r;
  logic [15:0] status_w;
  logic [47:0] scale_w;
  logic setup_wr_w;

  assign setup_wr_w = is_write_w && cmd_w == `CCRI_CMD_SETUP;
  // Only the three defined bits are kept so the rest read zero
  assign setup_nxt = param_w & `CCRI_CFG_MASK;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      setup_r <= `CCRI_SETUP_RESET;
    end else if (setup_wr_w) begin
      setup_r <= setup_nxt;
    end
  end

  // Setpoints are kept for read-back; they act only in bus control mode
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      vset_r <= 16'h0000;
      iset_r <= 16'h0000;
    end else if (is_write_w && cmd_w == 16'h0020) begin
      vset_r <= param_w;
    end else if (is_write_w && cmd_w == 16'h0030) begin
      iset_r <= param_w;
    end
  end

  assign bus_control_out = setup_r[`CCRI_CFG_BUS_CTRL];
  assign power_up_mode_out = setup_r[`CCRI_CFG_INIT_HI:`CCRI_CFG_INIT_LO];
  assign setup_write_out = setup_wr_w;
  assign output_voltage_setpoint_out = bus_control_out ? vset_r : output_voltage_setpoint_in;
  assign output_current_setpoint_out = bus_control_out ? iset_r : output_current_setpoint_in;
  assign fault_flags_out = fault_in;

  always_comb begin
    status_w = 16'h0000;
    status_w[`CCRI_ST_MASTER] = status_in.is_master;
    status_w[`CCRI_ST_SECONDARY_OUTPUT_GOOD] = status_in.secondary_output_good;
    status_w[`CCRI_ST_POWER_FACTOR_STAGE_GOOD] = status_in.power_factor_stage_good;
    status_w[`CCRI_ST_DUMMY] = status_in.dummy_load_active;
    status_w[`CCRI_ST_INIT] = status_in.in_init;
    status_w[`CCRI_ST_MEMERR] = status_in.param_memory_error;
  end

  assign scale_w = {16'h0000,
                    4'h0, ccri_code_ok(scale_in.input_current_multiplier),
                    4'h0, ccri_code_ok(scale_in.temperature_multiplier),
                    ccri_code_ok(scale_in.fan_speed_multiplier),
                    ccri_code_ok(scale_in.input_voltage_multiplier),
                    ccri_code_ok(scale_in.output_current_multiplier),
                    ccri_code_ok(scale_in.output_voltage_multiplier)};

  // =====================================
  // Read selection, byte 0 in the low lane
  always_comb begin
    rd_data_w = 48'h0;
    rd_len_w = 8'h00;
    known_w = 1'b1;
    unique case (cmd_w)
      `CCRI_CMD_DATE: begin
        rd_data_w = date_text_in;
        rd_len_w = 8'h06;
      end
      `CCRI_CMD_SER_LO: begin
        rd_data_w = date_text_in;
        rd_len_w = 8'h06;
      end
      `CCRI_CMD_SER_HI: begin
        rd_data_w = count_text_in;
        rd_len_w = 8'h06;
      end
      `CCRI_CMD_SCALE: begin
        rd_data_w = scale_w;
        rd_len_w = 8'h06;
      end
      `CCRI_CMD_STATUS: begin
        rd_data_w = {32'h0, status_w};
        rd_len_w = 8'h02;
      end
      `CCRI_CMD_SETUP: begin
        rd_data_w = {32'h0, setup_r};
        rd_len_w = 8'h02;
      end
      16'h0020: begin
        rd_data_w = {32'h0, vset_r};
        rd_len_w = 8'h02;
      end
      16'h0030: begin
        rd_data_w = {32'h0, iset_r};
        rd_len_w = 8'h02;
      end
      16'h0040: begin
        rd_data_w = {40'h0, fault_in};
        rd_len_w = 8'h02;
      end
      default: begin
        known_w = 1'b0;
      end
    endcase
  end

  // =====================================
  // Response frame; a request is dropped while a reply still waits
  ccri_frame_t resp_nxt;
  always_comb begin
    resp_nxt = '0;
    resp_nxt.id = `CCRI_ID_RESP | {12'h000, unit_addr_in};
    resp_nxt.dlc = 4'((rd_len_w + 8'h02));
    resp_nxt.data[0] = cmd_w[7:0];
    resp_nxt.data[1] = cmd_w[15:8];
    resp_nxt.data[7:2] = rd_data_w;
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_valid_out <= 1'b0;
      tx_frame_out <= '0;
    end else if (tx_valid_out) begin
      tx_valid_out <= !tx_ready_in;
    end else if (is_read_w && known_w) begin
      tx_valid_out <= 1'b1;
      tx_frame_out <= resp_nxt;
    end
  end
  // Writes to read-only commands fall through with no storage
endmodule

/* sim/ccri_link_model.sv */
`timescale 1ns/1ns
// ====================
// Reply acceptor; the stall lets a reply wait so its hold can be seen
module ccri_link_model (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic tx_valid_in,
  input wire logic [3:0] stall_in,
  output logic tx_ready_out
);
  logic [3:0] wait_r;
  assign tx_ready_out = tx_valid_in && (wait_r >= stall_in);
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) wait_r <= 4'h0;
    else wait_r <= (tx_valid_in && !tx_ready_out) ? wait_r + 4'h1 : 4'h0;
  end
endmodule

/* sim/ccri_top_props.sv */
`timescale 1ns/1ns
module ccri_top_props #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic [ADDR_W-1:0] unit_addr_in,
  input wire logic rx_valid_in,
  input wire ccri_pkg::ccri_frame_t rx_frame_in,
  input wire logic tx_ready_in,
  input wire logic tx_valid_out,
  input wire ccri_pkg::ccri_frame_t tx_frame_out,
  input wire ccri_pkg::ccri_status_t status_in,
  input wire logic [15:0] output_voltage_setpoint_in,
  input wire logic bus_control_out,
  input wire logic [1:0] power_up_mode_out,
  input wire logic setup_write_out,
  input wire logic [15:0] output_voltage_setpoint_out
);
  import ccri_pkg::*;
  wire hit = rx_valid_in && rx_frame_in.id[19:8] == 12'hC01 && rx_frame_in.id[ADDR_W-1:0] == unit_addr_in;
  wire [15:0] cmd = {rx_frame_in.data[1], rx_frame_in.data[0]};
  wire rd_st = hit && rx_frame_in.dlc == 4'h2 && cmd == 16'h00C1 && !tx_valid_out;
  wire wr_cfg = hit && rx_frame_in.dlc == 4'h4 && cmd == 16'h00C2;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  AST_STATUS_BYTE:
    assert property (rd_st |=> tx_valid_out && tx_frame_out.data[3] == 8'h00 && tx_frame_out.data[2] ==
      {1'b0, $past(status_in[5:3]), 1'b0, $past(status_in[2:0])}) else $error("bad status");
  AST_REPLY_HEAD:
    assert property (rd_st |=> tx_frame_out.id == {12'hC00, $past(rx_frame_in.id[7:0])} &&
      tx_frame_out.dlc == 4'h4 && tx_frame_out.data[0] == 8'hC1 && tx_frame_out.data[1] == 8'h00)
      else $error("bad head");
  AST_HOLD:
    assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_frame_out)) else $error("no hold");
  AST_RELEASE:
    assert property (tx_valid_out && tx_ready_in |=> !tx_valid_out) else $error("no release");
  AST_IGNORE_OTHER:
    assert property (rx_valid_in && rx_frame_in.id[ADDR_W-1:0] != unit_addr_in && !tx_valid_out |=> !tx_valid_out)
      else $error("answered other");
  AST_SETUP_STORE:
    assert property (wr_cfg |=> bus_control_out == $past(rx_frame_in.data[2][0]) &&
      power_up_mode_out == $past(rx_frame_in.data[2][2:1])) else $error("setup lost");
  AST_SETUP_PULSE:
    assert property (wr_cfg |-> setup_write_out) else $error("no pulse");
  AST_SETUP_KEEP:
    assert property (!wr_cfg |=> $stable({bus_control_out, power_up_mode_out})) else $error("setup moved");
  AST_ANALOG:
    assert property (!bus_control_out |-> output_voltage_setpoint_out == output_voltage_setpoint_in)
      else $error("bad mux");
  cover property (rd_st);
  cover property (wr_cfg);
  cover property (tx_valid_out && !tx_ready_in);
endmodule
bind ccri_top ccri_top_props #(.ADDR_W(ADDR_W)) u_props (.clk_sys_in, .arst_n_in, .unit_addr_in, .rx_valid_in,
  .rx_frame_in, .tx_ready_in, .tx_valid_out, .tx_frame_out, .status_in, .output_voltage_setpoint_in,
  .bus_control_out, .power_up_mode_out, .setup_write_out, .output_voltage_setpoint_out);

/* sim/ccri_top_tb.sv */
`timescale 1ns/1ns
module ccri_top_tb;
  import ccri_pkg::*;
  logic clk_sys_in = 0, arst_n_in = 0, rx_valid_in = 0, tx_ready_in, tx_valid_out, bus_control_out, setup_write_out;
  logic [7:0] unit_addr_in = 8'h01, fault_in = 8'hA5, fault_flags_out;
  logic [15:0] output_voltage_setpoint_in = 16'h1234, output_current_setpoint_in = 16'h5678, vout, iout;
  logic [1:0] power_up_mode_out;
  logic [47:0] date_text_in = 48'h313031303831, count_text_in = 48'h313030303030;
  ccri_scale_t scale_in = 24'h90A654;
  ccri_status_t status_in = 6'h2A;
  ccri_frame_t rx_frame_in = '0, tx_frame_out, got;
  logic [3:0] stall = 4'h0;
  int errors = 0, checked = 0, replies = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) if (tx_valid_out && tx_ready_in) begin
    got <= tx_frame_out;
    replies <= replies + 1;
  end
  ccri_top dut (.clk_sys_in, .arst_n_in, .unit_addr_in, .rx_valid_in, .rx_frame_in, .tx_ready_in, .tx_valid_out,
    .tx_frame_out, .date_text_in, .count_text_in, .scale_in, .status_in, .fault_in, .output_voltage_setpoint_in,
    .output_current_setpoint_in, .bus_control_out, .power_up_mode_out, .setup_write_out,
    .output_voltage_setpoint_out(vout), .output_current_setpoint_out(iout), .fault_flags_out);
  ccri_link_model link (.clk_sys_in, .arst_n_in, .tx_valid_in(tx_valid_out), .stall_in(stall), .tx_ready_out(tx_ready_in));
  // ====================
  // Checking and framing
  task automatic tally_and_finish();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [87:0] g, input logic [87:0] e, input string m);
    checked++;
    if (g !== e) begin
      errors++;
      $display("Error %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic send(input logic [19:0] id, input logic [3:0] dlc, input logic [31:0] d);
    @(negedge clk_sys_in);
    rx_frame_in = {id, dlc, 32'h0, d};
    rx_valid_in = 1;
    @(negedge clk_sys_in);
    rx_valid_in = 0;
  endtask
  // Bytes above the length are not part of the reply, so they are masked
  task automatic rd(input logic [15:0] cmd, input logic [3:0] dlc, input logic [47:0] v);
    int n;
    logic [63:0] g;
    n = replies;
    send(20'hC0101, 4'h2, {16'h0, cmd});
    for (int i = 0; i < 40 && replies == n; i++) @(negedge clk_sys_in);
    if (replies == n) begin
      errors++;
      $display("Error %0t no reply", $time);
      tally_and_finish();
    end
    g = got.data;
    for (int i = dlc; i < 8; i++) g[i*8 +: 8] = 8'h00;
    chk({got.id, got.dlc, g}, {20'hC0001, dlc, v, cmd}, "reply");
  endtask
  task automatic none(input logic [19:0] id, input logic [3:0] dlc, input logic [31:0] d);
    int n;
    n = replies;
    send(id, dlc, d);
    repeat (20) @(negedge clk_sys_in);
    chk(88'(replies - n), 88'h0, "silent");
  endtask
  // ====================
  // Scenarios
  task automatic t_text();
    rd(16'h0086, 4'h8, date_text_in);
    rd(16'h0087, 4'h8, date_text_in);
    rd(16'h0088, 4'h8, count_text_in);
    rd(16'h00C0, 4'h8, 48'h000009000654);
  endtask
  task automatic t_status();
    rd(16'h00C1, 4'h4, 48'h52);
    status_in = 6'h15;
    rd(16'h00C1, 4'h4, 48'h25);
    rd(16'h0040, 4'h4, 48'hA5);
    chk(88'(fault_flags_out), 88'hA5, "fault");
  endtask
  task automatic t_setup();
    for (int k = 0; k < 8; k++) begin
      send(20'hC0101, 4'h4, {16'hFFF8 | 16'(k), 16'h00C2});
      chk(88'({power_up_mode_out, bus_control_out}), 88'(k), "setup");
      rd(16'h00C2, 4'h4, 48'(k));
    end
    send(20'hC0101, 4'h4, 32'h15E00020);
    send(20'hC0101, 4'h4, 32'h0BB80030);
    chk(88'({vout, iout}), 88'h15E00BB8, "bus set");
    send(20'hC0101, 4'h4, 32'h000000C2);
    chk(88'({vout, iout}), 88'h12345678, "analog");
  endtask
  task automatic t_refuse();
    none(20'hC0102, 4'h2, 32'hC1);
    none(20'hC0201, 4'h2, 32'hC1);
    none(20'hC0101, 4'h2, 32'h99);
    none(20'hC0101, 4'h3, 32'hC1);
    none(20'hC0101, 4'h4, 32'hFFFF00C1);
    rd(16'h00C1, 4'h4, 48'h25);
  endtask
  task automatic t_stall();
    int n;
    stall = 4'h5;
    n = replies;
    send(20'hC0101, 4'h2, 32'hC1);
    send(20'hC0101, 4'h2, 32'hC0);
    repeat (30) @(negedge clk_sys_in);
    chk(88'(replies - n), 88'h1, "one reply");
    chk(88'(got.data[1:0]), 88'h00C1, "kept reply");
    stall = 4'h0;
  endtask
  initial begin
    repeat (16) @(negedge clk_sys_in);
    arst_n_in = 1;
    t_text();
    t_status();
    t_setup();
    t_refuse();
    t_stall();
    tally_and_finish();
  end
endmodule
